// ===== bmp_pkg.sv
// Constants and types for the buck mode and protection controller
package bmp_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int unsigned CT_RUN = 0;
  localparam int unsigned CT_SYNC = 1;
  localparam int unsigned SB_PG = 0;
  localparam int unsigned SB_CONT = 1;
  localparam int unsigned SB_OT = 2;
  localparam int unsigned SB_PIN = 3;
  localparam int unsigned SB_OVC = 4;
  localparam int unsigned SB_MODE = 7;
  localparam int unsigned SB_SEQ = 10;
  // ----------------------------------------
  // Strap level classes from the strap comparator
  // ----------------------------------------
  localparam logic [2:0] STRAP_GND = 3'h0;
  localparam logic [2:0] STRAP_R1 = 3'h1;
  localparam logic [2:0] STRAP_R2 = 3'h2;
  localparam logic [2:0] STRAP_R4 = 3'h4;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned SW_KHZ = 1100;
  localparam int unsigned PER_CYC = CLK_KHZ / SW_KHZ;
  localparam int unsigned HALF_CYC = PER_CYC / 2;
  localparam int unsigned LOSS_CYC = 2 * PER_CYC;
  localparam int unsigned PG_DLY_US = 1200;
  localparam int unsigned PG_DLY_CYC = (PG_DLY_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned SD_DLY_US = 10;
  localparam int unsigned SD_DLY_CYC = (SD_DLY_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned UV_DLY_US = 10;
  localparam int unsigned UV_DLY_CYC = (UV_DLY_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned HIC_DLY_US = 14500;
  localparam int unsigned HIC_DLY_CYC = (HIC_DLY_US * CLK_KHZ + 999) / 1000;
  localparam logic [2:0] OVC_LIMIT = 3'h4;
  localparam logic [1:0] CONT_RUN = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {MODE_FC_SLAVE, MODE_CUT_SLAVE, MODE_FREE_SKIP, MODE_CUT_MASTER,
                            MODE_FC_MASTER} bmp_mode_e;
  typedef enum logic [2:0] {SQ_OFF, SQ_LOCK, SQ_SOFT, SQ_RUN, SQ_OVP, SQ_FLOAT, SQ_HIC} bmp_seq_e;
  typedef enum logic [2:0] {PH_IDLE, PH_DH, PH_HS, PH_DL, PH_LS} bmp_stage_e;
  typedef struct packed {
    logic enable;
    logic supply_low_lockout_in;
    logic supply_low_lockout_bias;
    logic vin_above_1v;
    logic temp_over;
    logic temp_cooled;
    logic ramp_done;
    logic feedback_sense_hi;
    logic feedback_sense_lo;
    logic zero_cross;
    logic hs_over_current;
    logic ls_over_current;
    logic pwm_demand;
    logic [2:0] mode_strap_pin;
  } bmp_sense_s;
  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic phase_node_discharge;
    logic ramp_ref_sel;
    logic power_good_output_o;
    logic power_good_output_oe;
    logic sync_o;
    logic sync_oe;
  } bmp_drive_s;
endpackage : bmp_pkg

// ===== bmp_ctrl.sv
// Mode, switching and protection sequencer with APB status and control
//
// Overview of operation
// - Strap level selects one of five modes
// - Forced mode: high on-time, low off-time, clocked
// - Skip modes cut low switch at zero cross
// - Two pulses without zero cross enter continuous
// - Free skip: modulator alone times continuous cycles
// - Ramp reference until ramp reaches fixed level
// - Power good high only inside feedback window
// - Power good delayed on start and shutdown
// - Either supply low locks out; both ok restarts
// - High overcurrent ends on-time, low on
// - Fourth consecutive high overcurrent shuts down
// - Normal on-time clears the overcurrent count
// - Low overcurrent turns both off, shuts down
// - Hiccup wait after overcurrent, then restart
// - Overvoltage: low on until undervoltage, float
// - Undervoltage timer, then float and hiccup
// - Overtemperature off, resume after cooling
// - Enable low: switches off, discharge if input
// - Master drives half-period sync; slave follows
// - Slave without sync runs own clock
// - No sync while either side discontinuous
// - Slave starts on-time at sync falling edge
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
module bmp_ctrl #(
  parameter int unsigned PG_CYC = bmp_pkg::PG_DLY_CYC,
  parameter int unsigned HIC_CYC = bmp_pkg::HIC_DLY_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bmp_pkg::bmp_sense_s sense,
  input wire logic sync_i,
  input wire logic power_good_output_i,
  output bmp_pkg::bmp_drive_s drive
);
  import bmp_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  localparam logic [5:0] PER_LAST = 6'(PER_CYC - 1);
  localparam logic [5:0] HALF_C = 6'(HALF_CYC);
  localparam logic [5:0] LOSS_C = 6'(LOSS_CYC);
  localparam logic [15:0] PG_LAST = 16'(PG_CYC - 1);
  localparam logic [15:0] SD_LAST = 16'(SD_DLY_CYC - 1);
  localparam logic [8:0] UV_LAST = 9'(UV_DLY_CYC - 1);
  localparam logic [19:0] HIC_LAST = 20'(HIC_CYC - 1);

  // ----------------------------------------
  // Mode helpers
  // ----------------------------------------
  function automatic bmp_mode_e strap_mode(input logic [2:0] s);
    unique case (s)
      STRAP_GND: strap_mode = MODE_FC_SLAVE;
      STRAP_R1: strap_mode = MODE_CUT_SLAVE;
      STRAP_R2: strap_mode = MODE_FREE_SKIP;
      STRAP_R4: strap_mode = MODE_CUT_MASTER;
      default: strap_mode = MODE_FC_MASTER;
    endcase
  endfunction : strap_mode

  function automatic logic is_skip(input bmp_mode_e m);
    is_skip = (m == MODE_CUT_SLAVE) || (m == MODE_FREE_SKIP) || (m == MODE_CUT_MASTER);
  endfunction : is_skip

  function automatic logic is_master(input bmp_mode_e m);
    is_master = (m == MODE_CUT_MASTER) || (m == MODE_FC_MASTER);
  endfunction : is_master

  function automatic logic is_slave(input bmp_mode_e m);
    is_slave = (m == MODE_CUT_SLAVE) || (m == MODE_FC_SLAVE);
  endfunction : is_slave

  bmp_mode_e mode_q;
  bmp_seq_e seq_q, seq_d;
  bmp_stage_e stage_q, stage_d;
  logic [1:0] ctrl_q;
  logic ot_q, cont_q, zc_seen_q, pg_q, pg_d, sync_prev_q;
  logic [1:0] run_cnt_q;
  logic [2:0] ovc_cnt_q;
  logic [5:0] clk_cnt_q, loss_cnt_q;
  logic [15:0] pg_cnt_q;
  logic [8:0] uv_cnt_q;
  logic [19:0] hic_cnt_q;
  logic pwm_prev_q, pready_q, pslverr_q;
  logic [31:0] prdata_q;

  // ----------------------------------------
  // Derived events
  // ----------------------------------------
  logic tick, sync_fall, sync_live, use_sync, locked, start_ev, pwm_rise;
  logic active, hs_end, ovc_hit, ovc_kill, uv_done, in_win, zc_now;
  assign tick = clk_cnt_q == PER_LAST;
  assign sync_fall = sync_prev_q & ~sync_i;
  assign sync_live = loss_cnt_q != LOSS_C;
  // Slave follows sync only once both ends run continuous
  assign use_sync = is_slave(mode_q) & cont_q & sync_live;
  assign locked = cont_q & (mode_q != MODE_FREE_SKIP);
  assign pwm_rise = sense.pwm_demand & ~pwm_prev_q;
  assign start_ev = locked ? (use_sync ? sync_fall : tick) : pwm_rise;
  assign active = (seq_q == SQ_SOFT) || (seq_q == SQ_RUN);
  assign hs_end = (stage_q == PH_HS) & (~sense.pwm_demand | sense.hs_over_current);
  assign ovc_hit = (stage_q == PH_HS) & sense.hs_over_current;
  assign ovc_kill = ovc_hit & (ovc_cnt_q == OVC_LIMIT - 3'h1);
  assign uv_done = sense.feedback_sense_lo & (uv_cnt_q == UV_LAST);
  assign in_win = ~sense.feedback_sense_hi & ~sense.feedback_sense_lo;
  assign zc_now = zc_seen_q | (sense.zero_cross & (stage_q == PH_LS));

  // ----------------------------------------
  // Protection sequencer
  // ----------------------------------------
  // Enable outranks lockout, lockout outranks the fault states
  always_comb begin
    seq_d = seq_q;
    if (!sense.enable || !ctrl_q[CT_RUN]) begin
      seq_d = SQ_OFF;
    end else if (sense.supply_low_lockout_in || sense.supply_low_lockout_bias || ot_q) begin
      seq_d = SQ_LOCK;
    end else begin
      unique case (seq_q)
        SQ_OFF, SQ_LOCK: seq_d = SQ_SOFT;
        SQ_SOFT, SQ_RUN: begin
          if (sense.ls_over_current || ovc_kill) begin
            seq_d = SQ_HIC;
          end else if (sense.feedback_sense_hi) begin
            seq_d = SQ_OVP;
          end else if (seq_q == SQ_RUN && uv_done) begin
            seq_d = SQ_HIC;
          end else if (seq_q == SQ_SOFT && sense.ramp_done) begin
            seq_d = SQ_RUN;
          end
        end
        SQ_OVP: if (sense.feedback_sense_lo) seq_d = SQ_FLOAT;
        SQ_FLOAT: seq_d = SQ_FLOAT;
        SQ_HIC: if (hic_cnt_q == HIC_LAST) seq_d = SQ_SOFT;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seq_q <= SQ_OFF;
    else seq_q <= seq_d;
  end

  // Over-temperature latch; a new trip wins over cooling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ot_q <= 1'b0;
    else if (sense.temp_over) ot_q <= 1'b1;
    else if (sense.temp_cooled) ot_q <= 1'b0;
  end

  // Strap is re-read only while not switching, so mode never changes under load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_q <= MODE_FC_MASTER;
    else if (seq_q == SQ_OFF || seq_q == SQ_LOCK) mode_q <= strap_mode(sense.mode_strap_pin);
  end

  // Hiccup and undervoltage timers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hic_cnt_q <= '0;
      uv_cnt_q <= '0;
    end else begin
      hic_cnt_q <= (seq_q == SQ_HIC) ? hic_cnt_q + 20'h1 : '0;
      uv_cnt_q <= (seq_q == SQ_RUN && sense.feedback_sense_lo) ? uv_cnt_q + 9'h1 : '0;
    end
  end

  // ----------------------------------------
  // Power stage sequencing
  // ----------------------------------------
  // Every path between the two switches passes an all-off state
  always_comb begin
    stage_d = stage_q;
    if (seq_d == SQ_OVP) begin
      stage_d = (stage_q == PH_HS) ? PH_DL : PH_LS;
    end else if (seq_d != SQ_SOFT && seq_d != SQ_RUN) begin
      stage_d = PH_IDLE;
    end else begin
      unique case (stage_q)
        PH_IDLE: if (start_ev) stage_d = PH_DH;
        PH_DH: stage_d = PH_HS;
        PH_HS: if (hs_end) stage_d = PH_DL;
        PH_DL: stage_d = PH_LS;
        PH_LS: begin
          if (start_ev) stage_d = PH_DH;
          else if (is_skip(mode_q) && sense.zero_cross) stage_d = PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stage_q <= PH_IDLE;
    else stage_q <= stage_d;
  end

  // Overcurrent count; a full on-time without a trip clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ovc_cnt_q <= '0;
    else if (!active) ovc_cnt_q <= '0;
    else if (ovc_hit) ovc_cnt_q <= ovc_cnt_q + 3'h1;
    else if (hs_end) ovc_cnt_q <= '0;
  end

  // Conduction tracking, judged once per cycle start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_q <= 1'b0;
      run_cnt_q <= '0;
      zc_seen_q <= 1'b0;
    end else if (!active) begin
      cont_q <= 1'b0;
      run_cnt_q <= '0;
      zc_seen_q <= 1'b0;
    end else if (!is_skip(mode_q)) begin
      cont_q <= 1'b1;
      run_cnt_q <= '0;
      zc_seen_q <= 1'b0;
    end else if (start_ev) begin
      zc_seen_q <= 1'b0;
      if (zc_now) begin
        cont_q <= 1'b0;
        run_cnt_q <= '0;
      end else if (run_cnt_q == CONT_RUN - 2'h1) begin
        cont_q <= 1'b1;
      end else begin
        run_cnt_q <= run_cnt_q + 2'h1;
      end
    end else begin
      zc_seen_q <= zc_now;
    end
  end

  // ----------------------------------------
  // Internal clock and sync tracking
  // ----------------------------------------
  // Slave realigns its own clock to sync; once sync stops, no cycle starts until two periods pass without a falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cnt_q <= '0;
      loss_cnt_q <= LOSS_C;
      sync_prev_q <= 1'b1;
      pwm_prev_q <= 1'b0;
    end else begin
      sync_prev_q <= sync_i;
      pwm_prev_q <= sense.pwm_demand;
      if (tick || (use_sync && sync_fall)) clk_cnt_q <= '0;
      else clk_cnt_q <= clk_cnt_q + 6'h1;
      if (sync_fall) loss_cnt_q <= '0;
      else if (loss_cnt_q != LOSS_C) loss_cnt_q <= loss_cnt_q + 6'h1;
    end
  end

  // ----------------------------------------
  // Power good
  // ----------------------------------------
  // Window exit while running drops at once; shutdown waits the short delay
  always_comb begin
    pg_d = pg_q;
    if (!sense.vin_above_1v) pg_d = 1'b0;
    else if (!pg_q && seq_q == SQ_RUN && in_win && pg_cnt_q == PG_LAST) pg_d = 1'b1;
    else if (pg_q && seq_q == SQ_RUN && !in_win) pg_d = 1'b0;
    else if (pg_q && seq_q != SQ_RUN && pg_cnt_q == SD_LAST) pg_d = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_q <= 1'b0;
      pg_cnt_q <= '0;
    end else begin
      pg_q <= pg_d;
      if (pg_d != pg_q) pg_cnt_q <= '0;
      else if (!pg_q && seq_q == SQ_RUN && in_win) pg_cnt_q <= pg_cnt_q + 16'h1;
      else if (pg_q && seq_q != SQ_RUN) pg_cnt_q <= pg_cnt_q + 16'h1;
      else pg_cnt_q <= '0;
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Registered from next-state so outputs switch with the stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '{default: 1'b0, power_good_output_oe: 1'b0, sync_oe: 1'b1};
    end else begin
      drive.hs_on <= stage_d == PH_HS;
      drive.ls_on <= stage_d == PH_LS;
      drive.phase_node_discharge <= (seq_d == SQ_OFF) & sense.vin_above_1v;
      drive.ramp_ref_sel <= seq_d == SQ_SOFT;
      drive.power_good_output_o <= 1'b0;
      drive.power_good_output_oe <= pg_d;
      // Falling edge at half period puts the slave 180 degrees behind
      drive.sync_o <= clk_cnt_q < HALF_C;
      drive.sync_oe <= ~(is_master(mode_q) & cont_q & active & ctrl_q[CT_SYNC]);
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait-free access phase; unmapped addresses answer with an error
  logic hit_ctrl, hit_stat;
  logic [31:0] stat_w;
  assign hit_ctrl = paddr == CTRL_OFS;
  assign hit_stat = paddr == STAT_OFS;
  always_comb begin
    stat_w = '0;
    stat_w[SB_PG] = pg_q;
    stat_w[SB_CONT] = cont_q;
    stat_w[SB_OT] = ot_q;
    stat_w[SB_PIN] = power_good_output_i;
    stat_w[SB_OVC +: 3] = ovc_cnt_q;
    stat_w[SB_MODE +: 3] = mode_q;
    stat_w[SB_SEQ +: 3] = seq_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel & ~penable;
      if (psel && !penable) begin
        pslverr_q <= ~(hit_ctrl | hit_stat);
        prdata_q <= hit_ctrl ? {30'h0, ctrl_q} : (hit_stat ? stat_w : '0);
      end
    end
  end

  // Writes land only at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= CTRL_RST;
    else if (psel && penable && pready_q && pwrite && hit_ctrl) ctrl_q <= pwdata[1:0];
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_no_overlap:
    assert property (!(drive.hs_on && drive.ls_on)) else $error("both switches on");
  a_dead_gap:
    assert property ($rose(drive.ls_on) |-> !$past(drive.hs_on)) else $error("no dead cycle");
  a_zero_cut:
    assert property (stage_q == PH_LS && is_skip(mode_q) && sense.zero_cross && !start_ev && active
                     && seq_d == seq_q |=> !drive.ls_on) else $error("low switch kept after zero cross");
  a_hs_trip_off:
    assert property (ovc_hit |=> !drive.hs_on ##1 !drive.hs_on) else $error("high switch kept in overcurrent");
  a_ls_trip_kill:
    assert property (active && sense.ls_over_current && sense.enable && ctrl_q[CT_RUN] && !ot_q
                     && !sense.supply_low_lockout_in && !sense.supply_low_lockout_bias
                     |=> !drive.hs_on && !drive.ls_on && seq_q == SQ_HIC) else $error("low trip not handled");
  a_fourth_trip:
    assert property (ovc_kill && sense.enable && ctrl_q[CT_RUN] && !ot_q && !sense.supply_low_lockout_in
                     && !sense.supply_low_lockout_bias |=> seq_q == SQ_HIC) else $error("no shutdown at count four");
  a_discharge_on:
    assert property (seq_q == SQ_OFF && sense.vin_above_1v && !sense.enable
                     |=> drive.phase_node_discharge && !drive.hs_on && !drive.ls_on) else $error("discharge missing");
  a_pg_delay:
    assert property ($rose(drive.power_good_output_oe) |-> $past(pg_cnt_q) == PG_LAST) else $error("power good early");
  a_pg_window:
    assert property (pg_q && seq_q == SQ_RUN && !in_win |=> !drive.power_good_output_oe) else $error("pg outside window");
  a_uv_hiccup:
    assert property (seq_q == SQ_RUN && uv_done && sense.enable && ctrl_q[CT_RUN] && !ot_q && !sense.feedback_sense_hi
                     && !sense.supply_low_lockout_in && !sense.supply_low_lockout_bias && !sense.ls_over_current
                     |=> seq_q == SQ_HIC ##1 !drive.hs_on) else $error("undervoltage not handled");
  a_cont_entry:
    assert property ($rose(cont_q) && is_skip(mode_q) |-> $past(run_cnt_q) == CONT_RUN - 2'h1)
      else $error("continuous entered early");
endmodule : bmp_ctrl

// ===== bmp_sync_partner.sv
// Behavioural external clock standing on the sync pin of a slave
`timescale 1ns/1ns
module bmp_sync_partner #(
  parameter int HALF_NS = 456
) (
  input wire logic en,
  output logic sync_out
);
  // Near 1.1 MHz, +-20% band; edges never meet pclk rise
  always begin
    #HALF_NS;
    if (en) begin
      sync_out = ~sync_out;
    end
  end
  // Released pin shows the inverse of its last level, not a held copy
  always @(negedge en) begin
    if ($time > 0) begin
      sync_out = ~sync_out;
    end
  end
  initial begin
    sync_out = 1'b1;
  end
endmodule : bmp_sync_partner

// ===== bmp_ctrl_bench.sv
// Self-checking bench for the mode and protection sequencer
`timescale 1ns/1ns
module bmp_ctrl_bench;
  import bmp_pkg::*;
  localparam int PGC = 20;
  localparam int HICC = 30;
  localparam int LIMIT = 30000;
  localparam logic [31:0] SQM = 32'h1c00;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
  } bmp_exp_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm_q;
  logic part_en, part_sync, sync_w, pg_w, hsp, lsp, syp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [2:0] st [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7, 3'h3};
  logic [2:0] md [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
  bmp_sense_s sn, sense_c;
  bmp_drive_s drv;
  bmp_exp_s exq [$];
  bmp_exp_s ex;
  int miscompares, total_checks, cyc, seed, pcnt, hs_rise, sy_fall, t0, i;

  bmp_ctrl #(.PG_CYC(PGC), .HIC_CYC(HICC)) bmp_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense(sense_c), .sync_i(sync_w), .power_good_output_i(pg_w), .drive(drv));
  bmp_sync_partner bmp_sync_partner_i (.en(part_en), .sync_out(part_sync));

  // Shared pins: sync from whoever drives it, power good high only while its output enable is set
  assign sync_w = drv.sync_oe ? part_sync : drv.sync_o;
  assign pg_w = drv.power_good_output_oe ? 1'b1 : drv.power_good_output_o;
  always #20 pclk = ~pclk;
  always_comb begin
    sense_c = sn;
    sense_c.pwm_demand = pwm_q;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic summarize();
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic ck(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : ck

  // One APB transfer; the expected answer is queued for the watcher
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ed,
                     input logic [31:0] m, input logic ee);
    int n;
    exq.push_back('{ed, m, ee});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    ck("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Poll status until a field settles; the poll count bounds the wait
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v, input int polls);
    int k;
    for (k = 0; k < polls; k++) begin
      apb(1'b0, STAT_OFS, 32'h0, 32'h0, 32'h0, 1'b0);
      if ((rd & m) === v) begin
        k = polls;
      end
    end
    ck("stat_field", v, rd & m);
  endtask : wait_stat

  function automatic logic [31:0] sq(input logic [2:0] s);
    return {19'h0, s, 10'h0};
  endfunction : sq

  // ----------------------------------------
  // Modulator stand-in, timeout and watcher
  // ----------------------------------------
  // On-time request for 9 of every 30 clocks, unrelated to the internal tick
  always @(posedge pclk) begin
    pcnt <= (pcnt == 29) ? 0 : pcnt + 1;
    pwm_q <= (pcnt < 9);
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      summarize();
    end
  end
  // Mid-cycle: answers are settled, high-switch rising edges and sync falling edges are counted
  always @(negedge pclk) begin
    if (presetn === 1'b1) begin
      if (psel && penable && pready === 1'b1) begin
        ex = exq.pop_front();
        ck("prdata", ex.d, prdata & ex.m);
        ck("pslverr", {31'h0, ex.e}, {31'h0, pslverr});
      end
      ck("dead_time", 32'h0, {31'h0, (drv.hs_on & (drv.ls_on | lsp)) | (hsp & drv.ls_on)});
      hs_rise = hs_rise + ((drv.hs_on & ~hsp) ? 1 : 0);
      sy_fall = sy_fall + ((syp & ~sync_w) ? 1 : 0);
      hsp = drv.hs_on;
      lsp = drv.ls_on;
      syp = sync_w;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h28f7;
    {miscompares, total_checks, cyc, pcnt, hs_rise, sy_fall} = '0;
    {pclk, presetn, psel, penable, pwrite, pwm_q, part_en, hsp, lsp} = '0;
    syp = 1'b1;
    paddr = '0;
    pwdata = '0;
    sn = '0;
    sn.vin_above_1v = 1'b1;
    sn.mode_strap_pin = 3'h7;
    repeat (5) @(posedge pclk);
    ck("reset_drive", 32'h1, {24'h0, drv});
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0, {30'h0, CTRL_RST}, 32'h3, 1'b0);
    apb(1'b0, 12'h008, 32'h0, 32'h0, 32'h0, 1'b1);
    apb(1'b1, STAT_OFS, 32'hffff_ffff, 32'h0, 32'h0, 1'b0);
    @(negedge pclk);
    ck("discharge", 32'h1, {29'h0, drv.hs_on, drv.ls_on, drv.phase_node_discharge});
    @(posedge pclk);
    sn.vin_above_1v <= 1'b0;
    repeat (3) @(negedge pclk);
    ck("discharge", 32'h0, {31'h0, drv.phase_node_discharge});
    @(posedge pclk);
    sn.vin_above_1v <= 1'b1;
    // Every strap class, read back while idle
    for (i = 0; i < 6; i++) begin
      sn.mode_strap_pin <= st[i];
      repeat (3) @(posedge pclk);
      apb(1'b0, STAT_OFS, 32'h0, {22'h0, md[i], 7'h0}, 32'h380, 1'b0);
    end
    rnd = $random(seed);
    apb(1'b1, CTRL_OFS, {rnd[31:2], 2'b10}, 32'h0, 32'h0, 1'b0);
    sn.enable <= 1'b1;
    apb(1'b0, STAT_OFS, 32'h0, sq(3'h0), SQM, 1'b0);
    apb(1'b1, CTRL_OFS, {rnd[31:2], 2'b11}, 32'h0, 32'h0, 1'b0);
    wait_stat(SQM, sq(3'h2), 5);
    ck("ramp_ref", 32'h1, {31'h0, drv.ramp_ref_sel});
    sn.ramp_done <= 1'b1;
    wait_stat(SQM, sq(3'h3), 5);
    ck("ramp_ref", 32'h0, {31'h0, drv.ramp_ref_sel});
    ck("pg_early", 32'h0, {31'h0, drv.power_good_output_oe});
    repeat (PGC + 10) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0, 32'h9, 32'h9, 1'b0);
    ck("sync_drive", 32'h0, {31'h0, drv.sync_oe});
    {hs_rise, sy_fall} = '0;
    repeat (220) @(posedge pclk);
    ck("sync_pulses", 32'h1, {31'h0, sy_fall >= 9 && sy_fall <= 11});
    ck("fixed_rate", 32'h1, {31'h0, hs_rise >= 9 && hs_rise <= 11});
    sn.feedback_sense_lo <= 1'b1;
    repeat (3) @(negedge pclk);
    ck("pg_window", 32'h0, {31'h0, drv.power_good_output_oe});
    @(posedge pclk);
    sn.feedback_sense_lo <= 1'b0;
    // Single high-side trip ends the on-time, count shows one, then clears
    do @(negedge pclk); while (drv.hs_on !== 1'b1 || !pwm_q);
    @(posedge pclk);
    sn.hs_over_current <= 1'b1;
    @(posedge pclk);
    sn.hs_over_current <= 1'b0;
    @(negedge pclk);
    ck("hs_trip", 32'h0, {31'h0, drv.hs_on});
    repeat (2) @(negedge pclk);
    ck("ls_after", 32'h1, {31'h0, drv.ls_on});
    apb(1'b0, STAT_OFS, 32'h0, 32'h10, 32'h70, 1'b0);
    repeat (60) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0, 32'h0, 32'h70, 1'b0);
    sn.hs_over_current <= 1'b1;
    wait_stat(SQM, sq(3'h6), 100);
    ck("hiccup_off", 32'h0, {30'h0, drv.hs_on, drv.ls_on});
    sn.hs_over_current <= 1'b0;
    t0 = cyc;
    wait_stat(SQM, sq(3'h3), 30);
    ck("hiccup_len", 32'h1, {31'h0, cyc - t0 >= HICC - 4 && cyc - t0 <= HICC + 15});
    sn.ls_over_current <= 1'b1;
    wait_stat(SQM, sq(3'h6), 5);
    ck("ls_trip", 32'h0, {30'h0, drv.hs_on, drv.ls_on});
    sn.ls_over_current <= 1'b0;
    wait_stat(SQM, sq(3'h3), 30);
    sn.feedback_sense_hi <= 1'b1;
    wait_stat(SQM, sq(3'h4), 5);
    ck("ovp_low_on", 32'h1, {30'h0, drv.hs_on, drv.ls_on});
    sn.feedback_sense_hi <= 1'b0;
    sn.feedback_sense_lo <= 1'b1;
    wait_stat(SQM, sq(3'h5), 5);
    ck("float", 32'h0, {30'h0, drv.hs_on, drv.ls_on});
    sn.feedback_sense_lo <= 1'b0;
    sn.enable <= 1'b0;
    repeat (3) @(posedge pclk);
    sn.enable <= 1'b1;
    wait_stat(SQM, sq(3'h3), 10);
    sn.feedback_sense_lo <= 1'b1;
    repeat (200) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0, sq(3'h3), SQM, 1'b0);
    wait_stat(SQM, sq(3'h6), 40);
    sn.feedback_sense_lo <= 1'b0;
    wait_stat(SQM, sq(3'h3), 30);
    // Either supply alone locks out
    for (i = 0; i < 2; i++) begin
      sn.supply_low_lockout_in <= (i == 0);
      sn.supply_low_lockout_bias <= (i == 1);
      wait_stat(SQM, sq(3'h1), 5);
      sn.supply_low_lockout_in <= 1'b0;
      sn.supply_low_lockout_bias <= 1'b0;
      wait_stat(SQM, sq(3'h3), 10);
    end
    sn.temp_over <= 1'b1;
    wait_stat(SQM, sq(3'h1), 5);
    sn.temp_over <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0, sq(3'h1), SQM, 1'b0);
    sn.temp_cooled <= 1'b1;
    wait_stat(SQM, sq(3'h3), 10);
    sn.temp_cooled <= 1'b0;
    // Cutoff-skip master: zero cross keeps it discontinuous and off the sync pin
    sn.enable <= 1'b0;
    sn.mode_strap_pin <= 3'h4;
    sn.zero_cross <= 1'b1;
    repeat (3) @(posedge pclk);
    sn.enable <= 1'b1;
    wait_stat(SQM, sq(3'h3), 10);
    repeat (60) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0, 32'h0, 32'h2, 1'b0);
    ck("sync_dcm", 32'h1, {31'h0, drv.sync_oe});
    sn.zero_cross <= 1'b0;
    wait_stat(32'h2, 32'h2, 40);
    repeat (3) @(negedge pclk);
    ck("sync_ccm", 32'h0, {31'h0, drv.sync_oe});
    // Free skip: on-times follow the modulator, not the tick
    @(posedge pclk);
    sn.enable <= 1'b0;
    sn.mode_strap_pin <= 3'h2;
    repeat (3) @(posedge pclk);
    sn.enable <= 1'b1;
    wait_stat(32'h2, 32'h2, 40);
    hs_rise = 0;
    repeat (240) @(posedge pclk);
    ck("free_rate", 32'h1, {31'h0, hs_rise >= 7 && hs_rise <= 9});
    // Slave following an external clock, then losing it
    @(posedge pclk);
    sn.enable <= 1'b0;
    sn.mode_strap_pin <= 3'h0;
    repeat (3) @(posedge pclk);
    sn.enable <= 1'b1;
    part_en <= 1'b1;
    wait_stat(SQM, sq(3'h3), 10);
    repeat (50) @(posedge pclk);
    {hs_rise, sy_fall} = '0;
    repeat (400) @(posedge pclk);
    ck("sync_follow", 32'h1, {31'h0, hs_rise - sy_fall <= 1 && sy_fall - hs_rise <= 1});
    part_en <= 1'b0;
    repeat (50) @(posedge pclk);
    hs_rise = 0;
    repeat (220) @(posedge pclk);
    ck("own_clock", 32'h1, {31'h0, hs_rise >= 9 && hs_rise <= 11});
    summarize();
  end
endmodule : bmp_ctrl_bench
